// [rtl/lfim_consts.svh]
/*
 Offsets, codes, field positions, reset values and timing figures of the
 transponder link. Assumes a 250 MHz core clock; times are in microseconds.
*/
`ifndef LFIM_CONSTS_SVH
`define LFIM_CONSTS_SVH

// core clock rate
`define LFIM_CLK_MHZ 250
`define LFIM_HZ_PER_MHZ 1000000
// uplink bit time, 32 carrier periods of 8 us
`define LFIM_BIT_US 256
// pause between request and response
`define LFIM_PAUSE_US 2000
// error waveform frequency and its length in periods
`define LFIM_ERR_HZ 1000
`define LFIM_ERR_PERIODS 8
// pulse length decision points of the downlink
`define LFIM_BPL_SPLIT_US 200
`define LFIM_QPL_SPLIT1_US 150
`define LFIM_QPL_SPLIT2_US 250
`define LFIM_QPL_SPLIT3_US 350
`define LFIM_PULSE_MAX_US 500

// frame layout
`define LFIM_HEADER 8'hFE
`define LFIM_CMD_BITS 8
`define LFIM_CRC_BITS 8
`define LFIM_BLOCK_BITS 128
`define LFIM_UID_BITS 32
`define LFIM_STAT_BITS 8
`define LFIM_CRC8_POLY 8'h07
`define LFIM_CRC8_INIT 8'h00

// command codes and their checksums
`define LFIM_CMD_UID 4'h0
`define LFIM_CHK_UID 4'h0
`define LFIM_CMD_AUTH 4'h1
`define LFIM_CHK_AUTH 4'h3
`define LFIM_CMD_STAT 4'h2
`define LFIM_CHK_STAT 4'h6

// stored byte index, relative to byte 0x800
`define LFIM_NVM_UID0 5'h00
`define LFIM_NVM_MODEL 5'h11
`define LFIM_NVM_CHAL_LEN 5'h15
`define LFIM_NVM_RESP_LEN 5'h16
`define LFIM_MODEL_BIT 2
`define LFIM_STATUS_RESET 8'h00

`endif

// [rtl/lfim_pkg.sv]
/*
 Types shared by the transponder link and its surroundings.
 Assumes nothing beyond a SystemVerilog tool.
*/
package lfim_pkg;
    // downlink coding selected by configuration
    typedef enum logic [1:0] {
        BINARY_PULSE_LENGTH_CODING,
        QUAD_PULSE_LENGTH_CODING,
        DAMPED_PHASE_KEYING
    } lfim_dl_t;
    // uplink coding
    typedef enum logic {UL_MANCHESTER, UL_BIPHASE} lfim_ul_t;
    // low nibble of the status byte
    typedef enum logic [3:0] {ST_OK, ST_CMD_CHECK, ST_CMD_UNKNOWN, ST_CRC, ST_LENGTH} lfim_stat_t;
    // session sequencer
    typedef enum logic [2:0] {S_DETECT, S_RX, S_PAUSE, S_TX, S_ERRW} lfim_state_t;
endpackage

// [rtl/lfim_nvm.sv]
/*
 Small byte store holding identity and configuration bytes.
 Assumes a preload port driven by the surroundings; read data registered.
*/
`timescale 1ns/1ps
module lfim_nvm #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    // clock
    input wire logic ref_clk_in,
    input wire logic clk_en_in,
    // write port
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    // read port
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [2**AW];

    // no reset on the array, contents come from the preload port
    always_ff @(posedge ref_clk_in) begin
        if (clk_en_in) begin
            if (we_in) begin
                mem[waddr_in] <= wdata_in;
            end
            rdata_out <= mem[raddr_in];
        end
    end
endmodule

// [rtl/lfim_link.sv]
/*
 Transponder side of the low-frequency link: channel detection header,
 downlink decoding, request parsing, uplink encoding and error waveform.
 Assumes field_in and all inputs synchronous to ref_clk_in, an external
 block cipher on the aes ports, and preloaded identity/config bytes.
*/
`timescale 1ns/1ps
`include "lfim_consts.svh"

// What this block does
// - send alternating header until gap opens link
// - downlink is field on/off, gap separated
// - binary coding: one pulse, one bit
// - quad coding: one pulse, two bits
// - damped keying: gap in second half
// - damping pulls coil to half amplitude
// - uplink biphase or Manchester by configuration
// - request, then 2 ms pause, then response
// - on error send 1 kHz waveform instead
// - record error cause for later status
// - normal response only without any error
// - payload and CRC only when command needs
// - response starts with fixed header byte
// - status mixes error and last command
// - challenge and response lengths from configuration
// - configuration bit selects one-way or mutual
// - lengths 104/128 and 56/80 suggested
// - response is truncated block cipher result
// - status high nibble echoes last command
// - serial from four bytes, MSB first
module lfim_link
    import lfim_pkg::*;
#(
    parameter int BIT_CYC = `LFIM_BIT_US * `LFIM_CLK_MHZ,
    parameter int PAUSE_CYC = `LFIM_PAUSE_US * `LFIM_CLK_MHZ,
    parameter int ERR_HALF_CYC = (`LFIM_CLK_MHZ * `LFIM_HZ_PER_MHZ) / (2 * `LFIM_ERR_HZ),
    parameter int ERR_PERIODS = `LFIM_ERR_PERIODS,
    parameter int BPL_SPLIT_CYC = `LFIM_BPL_SPLIT_US * `LFIM_CLK_MHZ,
    parameter int QPL_SPLIT1_CYC = `LFIM_QPL_SPLIT1_US * `LFIM_CLK_MHZ,
    parameter int QPL_SPLIT2_CYC = `LFIM_QPL_SPLIT2_US * `LFIM_CLK_MHZ,
    parameter int QPL_SPLIT3_CYC = `LFIM_QPL_SPLIT3_US * `LFIM_CLK_MHZ,
    parameter int PULSE_MAX_CYC = `LFIM_PULSE_MAX_US * `LFIM_CLK_MHZ
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // coil side
    input wire logic field_in,
    output logic damp_out,
    output logic link_open_out,
    // coding selection
    input lfim_dl_t dl_mode_in,
    input lfim_ul_t ul_code_in,
    // byte store preload
    input wire logic nvm_we_in,
    input wire logic [4:0] nvm_waddr_in,
    input wire logic [7:0] nvm_wdata_in,
    // block cipher
    output logic aes_start_out,
    output logic aes_mutual_out,
    output logic [127:0] aes_block_out,
    input wire logic aes_done_in,
    input wire logic [127:0] aes_result_in,
    // status
    output logic [7:0] status_out
);
    localparam int CW = $clog2(PAUSE_CYC + BIT_CYC + ERR_HALF_CYC + PULSE_MAX_CYC);

    // shared serial CRC step for receive check and transmit append
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic b);
        logic [7:0] s;
        s = {c[6:0], 1'b0};
        return (c[7] ^ b) ? (s ^ `LFIM_CRC8_POLY) : s;
    endfunction

    // known commands and their expected checksum, {known, check}
    function automatic logic [4:0] cmd_chk(input logic [3:0] code);
        unique case (code)
            `LFIM_CMD_UID: return {1'b1, `LFIM_CHK_UID};
            `LFIM_CMD_AUTH: return {1'b1, `LFIM_CHK_AUTH};
            `LFIM_CMD_STAT: return {1'b1, `LFIM_CHK_STAT};
            default: return 5'h00;
        endcase
    endfunction

    lfim_state_t st_q, st_d;
    logic fld_q, damp_q, damp_d, alt_q, ph_q, link_q, err_q, aes_wait_q, aes_start_q;
    logic seen_q, started_q;
    logic [CW-1:0] bt_q, pw_q, pc_q, ec_q;
    logic [7:0] eh_q;
    logic [1:0] pend_q, pbits_q;
    logic [8:0] rx_n_q, tx_n_q, tx_tot_q;
    logic [7:0] cmd_q, rxcrc_q, rcrc_q, tcrc_q, crc_n, status_q;
    logic [7:0] cfg_model_q, cfg_chal_q, cfg_resp_q, nvm_rdata;
    logic [31:0] uid_q;
    logic [127:0] chal_q, pay_q, blk_q;
    logic [135:0] tx_sr_q;
    logic [2:0] ld_q, ldp_q;
    logic [4:0] nvm_raddr, chk;
    logic half, bit_end, restart, rxv, rxb, pause_done, err_done, tx_last, frame_done;
    logic in_pay;
    lfim_stat_t frame_stat;

    assign half = bt_q >= CW'(BIT_CYC / 2);
    assign bit_end = bt_q == CW'(BIT_CYC - 1);
    assign restart = st_d != st_q;
    assign rxv = pend_q != 2'd0;
    assign rxb = pbits_q[1];
    assign chk = cmd_chk(cmd_q[7:4]);
    assign pause_done = pc_q == CW'(PAUSE_CYC - 1);
    assign err_done = st_q == S_ERRW && ec_q == CW'(ERR_HALF_CYC - 1)
        && eh_q == 8'(2 * ERR_PERIODS - 1);
    assign tx_last = st_q == S_TX && bit_end && tx_n_q == tx_tot_q + 9'd7;
    assign in_pay = tx_n_q >= 9'(`LFIM_CMD_BITS) && tx_n_q < tx_tot_q;
    assign crc_n = in_pay ? crc8(tcrc_q, tx_sr_q[135]) : tcrc_q;

    // session sequencer
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_DETECT: if (!field_in && damp_q) st_d = S_RX;
            S_RX: if (frame_done) st_d = S_PAUSE;
            S_PAUSE: begin
                if (pause_done && err_q) begin
                    st_d = S_ERRW;
                end else if (pause_done && !aes_wait_q) begin
                    st_d = S_TX;
                end
            end
            S_TX: if (tx_last) st_d = S_RX;
            S_ERRW: if (err_done) st_d = S_RX;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= S_DETECT;
            link_q <= 1'b0;
        end else if (clk_en_in) begin
            st_q <= st_d;
            if (st_q == S_DETECT && st_d == S_RX) begin
                link_q <= 1'b1;
            end
        end
    end

    // coil damping level; one means coil pulled to half amplitude
    always_comb begin
        damp_d = 1'b0;
        unique case (st_q)
            S_DETECT: damp_d = half ? ~alt_q : alt_q;
            S_RX: damp_d = dl_mode_in == DAMPED_PHASE_KEYING && half;
            S_PAUSE: damp_d = 1'b0;
            S_TX: begin
                if (ul_code_in == UL_BIPHASE) begin
                    damp_d = ph_q ^ (half & ~tx_sr_q[135]);
                end else begin
                    damp_d = half ? ~tx_sr_q[135] : tx_sr_q[135];
                end
            end
            S_ERRW: damp_d = ec_q < CW'(ERR_HALF_CYC / 2) ? 1'b1 : eh_q[0];
        endcase
    end

    // bit timer and encoder state; timer realigns on every state change
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bt_q <= '0;
            alt_q <= 1'b1;
            ph_q <= 1'b0;
            damp_q <= 1'b0;
            fld_q <= 1'b1;
        end else if (clk_en_in) begin
            fld_q <= field_in;
            damp_q <= damp_d;
            bt_q <= (restart || bit_end) ? '0 : bt_q + CW'(1);
            if (st_q == S_DETECT && bit_end) begin
                alt_q <= ~alt_q;
            end
            if (restart) begin
                ph_q <= 1'b0;
            end else if (st_q == S_TX && bit_end) begin
                ph_q <= ~ph_q;
            end
        end
    end

    // downlink symbol decoder, bits leave one per cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pw_q <= '0;
            pend_q <= 2'd0;
            pbits_q <= 2'd0;
            seen_q <= 1'b0;
            started_q <= 1'b0;
        end else if (clk_en_in) begin
            if (!field_in) begin
                pw_q <= '0;
            end else if (pw_q != '1) begin
                pw_q <= pw_q + CW'(1);
            end
            if (rxv) begin
                pend_q <= pend_q - 2'd1;
                pbits_q <= {pbits_q[0], 1'b0};
            end
            if (st_q != S_RX) begin
                pend_q <= 2'd0;
                seen_q <= 1'b0;
                started_q <= 1'b0;
            end else if (dl_mode_in == DAMPED_PHASE_KEYING) begin
                if (half && !field_in) begin
                    seen_q <= 1'b1;
                end
                if (bit_end) begin
                    seen_q <= 1'b0;
                    started_q <= started_q | seen_q;
                    if (started_q) begin
                        pend_q <= 2'd1;
                        pbits_q <= {seen_q, 1'b0};
                    end
                end
            end else if (fld_q && !field_in && pw_q <= CW'(PULSE_MAX_CYC)) begin
                if (dl_mode_in == QUAD_PULSE_LENGTH_CODING) begin
                    pend_q <= 2'd2;
                    pbits_q <= pw_q >= CW'(QPL_SPLIT3_CYC) ? 2'd3 :
                        pw_q >= CW'(QPL_SPLIT2_CYC) ? 2'd2 :
                        pw_q >= CW'(QPL_SPLIT1_CYC) ? 2'd1 : 2'd0;
                end else begin
                    pend_q <= 2'd1;
                    pbits_q <= {pw_q >= CW'(BPL_SPLIT_CYC), 1'b0};
                end
            end
        end
    end

    // request field collection
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_n_q <= 9'd0;
            cmd_q <= 8'h00;
            chal_q <= '0;
            rxcrc_q <= 8'h00;
            rcrc_q <= `LFIM_CRC8_INIT;
        end else if (clk_en_in) begin
            if (restart && st_d == S_RX) begin
                rx_n_q <= 9'd0;
                rcrc_q <= `LFIM_CRC8_INIT;
            end else if (st_q == S_RX && rxv) begin
                rx_n_q <= rx_n_q + 9'd1;
                if (rx_n_q < 9'(`LFIM_CMD_BITS)) begin
                    cmd_q <= {cmd_q[6:0], rxb};
                end else if (rx_n_q < 9'(`LFIM_CMD_BITS) + {1'b0, cfg_chal_q}) begin
                    chal_q <= {chal_q[126:0], rxb};
                    rcrc_q <= crc8(rcrc_q, rxb);
                end else begin
                    rxcrc_q <= {rxcrc_q[6:0], rxb};
                end
            end
        end
    end

    // end of request and its verdict
    always_comb begin
        frame_done = 1'b0;
        frame_stat = ST_OK;
        if (st_q == S_RX && rx_n_q == 9'(`LFIM_CMD_BITS)) begin
            if (!chk[4]) begin
                frame_done = 1'b1;
                frame_stat = ST_CMD_UNKNOWN;
            end else if (chk[3:0] != cmd_q[3:0]) begin
                frame_done = 1'b1;
                frame_stat = ST_CMD_CHECK;
            end else if (cmd_q[7:4] != `LFIM_CMD_AUTH) begin
                frame_done = 1'b1;
            end else if (cfg_chal_q == 8'h00 || cfg_chal_q > 8'(`LFIM_BLOCK_BITS)
                    || cfg_resp_q == 8'h00 || cfg_resp_q > 8'(`LFIM_BLOCK_BITS)) begin
                frame_done = 1'b1;
                frame_stat = ST_LENGTH;
            end
        end else if (st_q == S_RX && rx_n_q == 9'(`LFIM_CMD_BITS + `LFIM_CRC_BITS)
                + {1'b0, cfg_chal_q}) begin
            frame_done = 1'b1;
            frame_stat = rxcrc_q == rcrc_q ? ST_OK : ST_CRC;
        end
    end

    // status, response payload and cipher request
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= `LFIM_STATUS_RESET;
            err_q <= 1'b0;
            pay_q <= '0;
            tx_tot_q <= 9'(`LFIM_CMD_BITS);
            aes_wait_q <= 1'b0;
            aes_start_q <= 1'b0;
            blk_q <= '0;
        end else if (clk_en_in) begin
            aes_start_q <= 1'b0;
            if (aes_wait_q && aes_done_in) begin
                aes_wait_q <= 1'b0;
                pay_q <= aes_result_in;
            end
            if (frame_done) begin
                status_q <= {cmd_q[7:4], frame_stat};
                err_q <= frame_stat != ST_OK;
                if (frame_stat == ST_OK) begin
                    unique case (cmd_q[7:4])
                        `LFIM_CMD_UID: begin
                            pay_q <= {uid_q, 96'h0};
                            tx_tot_q <= 9'(`LFIM_CMD_BITS + `LFIM_UID_BITS);
                        end
                        `LFIM_CMD_STAT: begin
                            pay_q <= {status_q, 120'h0};
                            tx_tot_q <= 9'(`LFIM_CMD_BITS + `LFIM_STAT_BITS);
                        end
                        default: begin
                            aes_wait_q <= 1'b1;
                            aes_start_q <= 1'b1;
                            blk_q <= chal_q << (8'(`LFIM_BLOCK_BITS) - cfg_chal_q);
                            tx_tot_q <= 9'(`LFIM_CMD_BITS) + {1'b0, cfg_resp_q};
                        end
                    endcase
                end
            end
        end
    end

    // response shifter; the CRC drops into the top byte behind the payload
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_sr_q <= '0;
            tx_n_q <= 9'd0;
            tcrc_q <= `LFIM_CRC8_INIT;
        end else if (clk_en_in) begin
            if (restart && st_d == S_TX) begin
                tx_sr_q <= {`LFIM_HEADER, pay_q};
                tx_n_q <= 9'd0;
                tcrc_q <= `LFIM_CRC8_INIT;
            end else if (st_q == S_TX && bit_end) begin
                tcrc_q <= crc_n;
                tx_n_q <= tx_n_q + 9'd1;
                tx_sr_q <= {tx_sr_q[134:0], 1'b0};
                if (tx_n_q + 9'd1 == tx_tot_q) begin
                    tx_sr_q[135:128] <= crc_n;
                end
            end
        end
    end

    // pause and error waveform timing
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pc_q <= '0;
            ec_q <= '0;
            eh_q <= 8'h00;
        end else if (clk_en_in) begin
            if (st_q != S_PAUSE) begin
                pc_q <= '0;
            end else if (!pause_done) begin
                pc_q <= pc_q + CW'(1);
            end
            if (st_q != S_ERRW) begin
                ec_q <= '0;
                eh_q <= 8'h00;
            end else if (ec_q == CW'(ERR_HALF_CYC - 1)) begin
                ec_q <= '0;
                eh_q <= eh_q + 8'h01;
            end else begin
                ec_q <= ec_q + CW'(1);
            end
        end
    end

    // background walk over identity and configuration bytes
    always_comb begin
        unique case (ld_q)
            3'd4: nvm_raddr = `LFIM_NVM_MODEL;
            3'd5: nvm_raddr = `LFIM_NVM_CHAL_LEN;
            3'd6: nvm_raddr = `LFIM_NVM_RESP_LEN;
            default: nvm_raddr = `LFIM_NVM_UID0 + {3'd0, ld_q[1:0]};
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ld_q <= 3'd0;
            ldp_q <= 3'd7;
            uid_q <= 32'h0000_0000;
            cfg_model_q <= 8'h00;
            cfg_chal_q <= 8'h00;
            cfg_resp_q <= 8'h00;
        end else if (clk_en_in) begin
            ld_q <= ld_q == 3'd6 ? 3'd0 : ld_q + 3'd1;
            ldp_q <= ld_q;
            unique case (ldp_q)
                3'd0: uid_q[31:24] <= nvm_rdata;
                3'd1: uid_q[23:16] <= nvm_rdata;
                3'd2: uid_q[15:8] <= nvm_rdata;
                3'd3: uid_q[7:0] <= nvm_rdata;
                3'd4: cfg_model_q <= nvm_rdata;
                3'd5: cfg_chal_q <= nvm_rdata;
                3'd6: cfg_resp_q <= nvm_rdata;
                default: ;
            endcase
        end
    end

    lfim_nvm #(.AW(5), .DW(8)) u_nvm (
        .ref_clk_in(ref_clk_in),
        .clk_en_in(clk_en_in),
        .we_in(nvm_we_in),
        .waddr_in(nvm_waddr_in),
        .wdata_in(nvm_wdata_in),
        .raddr_in(nvm_raddr),
        .rdata_out(nvm_rdata)
    );

    assign damp_out = damp_q;
    assign link_open_out = link_q;
    assign status_out = status_q;
    assign aes_start_out = aes_start_q;
    assign aes_block_out = blk_q;
    assign aes_mutual_out = cfg_model_q[`LFIM_MODEL_BIT];

    chk_link_open: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        st_q == S_DETECT && !field_in && damp_q |=> st_q == S_RX && link_open_out)
        else $error("link did not open on damped gap");
    chk_quad_pair: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        st_q == S_RX && dl_mode_in == QUAD_PULSE_LENGTH_CODING && fld_q && !field_in
        && pw_q <= CW'(PULSE_MAX_CYC) |=> pend_q == 2'd2 ##1 pend_q == 2'd1)
        else $error("quad pulse did not yield two bits");
    chk_manch_mid: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        st_q == S_TX && ul_code_in == UL_MANCHESTER && bt_q == CW'(BIT_CYC / 2)
        |=> damp_q != $past(damp_q))
        else $error("no mid-bit transition in manchester");
    chk_pause_min: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        $rose(st_q == S_PAUSE) |-> (st_q == S_PAUSE) [*8])
        else $error("pause ended too early");
    chk_err_wave: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        st_q == S_PAUSE && pause_done && err_q |=> st_q == S_ERRW)
        else $error("error did not start error waveform");
    chk_no_resp_err: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        st_q == S_TX |-> !err_q)
        else $error("response sent after error");
    chk_hdr_first: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        st_q != S_TX ##1 st_q == S_TX |-> tx_sr_q[135:128] == `LFIM_HEADER)
        else $error("response does not open with header");
    chk_status_echo: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        frame_done |=> status_out[7:4] == $past(cmd_q[7:4]))
        else $error("status does not echo command");
    chk_aes_start: assert property (
        @(posedge ref_clk_in) disable iff (rst_in || !clk_en_in)
        frame_done && frame_stat == ST_OK && cmd_q[7:4] == `LFIM_CMD_AUTH
        |=> aes_start_out ##1 !aes_start_out)
        else $error("cipher not started once");
endmodule

// [dv/lfim_bs_model.sv]
/*
 base station stand-in: keys the field with binary or quad pulse lengths.
 assumes shortened splits: binary at 20 cycles, quad at 10, 20 and 30.
*/
`timescale 1ns/1ps
module lfim_bs_model (
    // clock
    input wire logic ref_clk_in,
    // coil side
    input wire logic damp_in,
    output logic field_out
);
    initial field_out = 1'b1;
    // gap during a damped half opens the link
    task automatic open_link(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(negedge ref_clk_in);
            ok = (damp_in === 1'b1);
        end
        field_out = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        field_out = 1'b1;
    endtask
    // idle field is too long to count, so the first gap adds no bit
    task automatic send(input logic [23:0] v, input int n, input int q = 1);
        repeat (50) @(negedge ref_clk_in);
        field_out = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        for (int i = n - 1; i >= 0; i -= q) begin
            field_out = 1'b1;
            // quad symbols 0..3 last 5, 15, 25 and 35 cycles
            repeat (q == 2 ? 5 + 10 * v[i -: 2] : 10 + 15 * v[i]) @(negedge ref_clk_in);
            field_out = 1'b0;
            repeat (4) @(negedge ref_clk_in);
        end
        field_out = 1'b1;
    endtask
endmodule

// [dv/tb_top.sv]
/*
 bench for the transponder link: uid, status, error and cipher sessions.
 assumes shortened timing parameters; both codings are exercised.
*/
`timescale 1ns/1ps
module tb_top;
    import lfim_pkg::*;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, damp_out, link_open_out, ok, en = 1'b1;
    lfim_dl_t dl = BINARY_PULSE_LENGTH_CODING;
    lfim_ul_t ul = UL_MANCHESTER;
    logic nvm_we_in = 1'b0, aes_start_out, aes_mutual_out, aes_done_in = 1'b0, mut_q = 1'b0;
    logic [4:0] nvm_waddr_in = 5'h00;
    logic [7:0] nvm_wdata_in = 8'h00, status_out, chal_q = 8'h00;
    logic [127:0] aes_block_out, aes_result_in = '0;
    wire logic field_in;
    int n_fail = 0, samples_checked = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    lfim_bs_model bs (.ref_clk_in(ref_clk_in), .damp_in(damp_out), .field_out(field_in));
    lfim_link #(.BIT_CYC(16), .PAUSE_CYC(40), .ERR_HALF_CYC(8), .ERR_PERIODS(2),
        .BPL_SPLIT_CYC(20), .QPL_SPLIT1_CYC(10), .QPL_SPLIT2_CYC(20), .QPL_SPLIT3_CYC(30),
        .PULSE_MAX_CYC(40)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(en),
        .field_in(field_in), .damp_out(damp_out), .link_open_out(link_open_out),
        .dl_mode_in(dl), .ul_code_in(ul),
        .nvm_we_in(nvm_we_in), .nvm_waddr_in(nvm_waddr_in), .nvm_wdata_in(nvm_wdata_in),
        .aes_start_out(aes_start_out), .aes_mutual_out(aes_mutual_out),
        .aes_block_out(aes_block_out), .aes_done_in(aes_done_in),
        .aes_result_in(aes_result_in), .status_out(status_out));
    // cipher stand-in answers the inverted block half a cycle after the start pulse rises
    always @(negedge ref_clk_in) begin
        aes_done_in <= aes_start_out;
        if (aes_start_out === 1'b1) begin
            aes_result_in <= ~aes_block_out;
            chal_q <= aes_block_out[127:120];
            mut_q <= aes_mutual_out;
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // first damped cycle marks the header; sample both halves of each bit
    // biphase opens at the idle level, so its leading header one shows no edge
    task automatic get_resp(input int n, output logic [47:0] r, output int t);
        logic h;
        int b;
        r = '0;
        t = 0;
        b = ul == UL_BIPHASE ? 16 : 0;
        while (damp_out !== 1'b1 && t < 400) begin
            @(negedge ref_clk_in);
            t++;
        end
        if (t == 400) begin
            n_fail++;
            finish_test();
        end
        r[n - 1] = b != 0;
        for (int i = n - 1 - b / 16; i >= 0; i--) begin
            repeat (4) @(negedge ref_clk_in);
            h = damp_out;
            repeat (8) @(negedge ref_clk_in);
            r[i] = b != 0 ? h == damp_out : h;
            repeat (4) @(negedge ref_clk_in);
        end
        chk("pause", 8'h01, {7'h0, t - b >= 30 && t - b <= 44});
    endtask
    task automatic t_uid();
        logic [47:0] r;
        int t;
        bs.send(24'h00_0000, 8);
        get_resp(48, r, t);
        chk("header", 8'hFE, r[47:40]);
        chk("uid msb", 8'hA5, r[39:32]);
        chk("uid lsb", 8'h0F, r[15:8]);
        chk("uid crc", crc8(32'hA53C_960F, 32), r[7:0]);
        chk("status", 8'h00, status_out);
    endtask
    task automatic t_err();
        logic [47:0] r;
        int t;
        bs.send(24'h00_0001, 8);
        get_resp(1, r, t);
        repeat (60) @(negedge ref_clk_in);
        chk("err status", 8'h01, status_out);
    endtask
    task automatic t_stat(input logic [7:0] prev, input int q);
        logic [47:0] r;
        int t;
        bs.send(24'h00_0026, 8, q);
        get_resp(24, r, t);
        chk("header", 8'hFE, r[23:16]);
        chk("stat byte", prev, r[15:8]);
        chk("stat crc", crc8({24'h0, prev}, 8), r[7:0]);
        chk("status", 8'h20, status_out);
    endtask
    task automatic t_auth();
        logic [47:0] r;
        int t;
        bs.send({16'h135B, crc8(32'h5B, 8)}, 24);
        get_resp(24, r, t);
        chk("challenge", 8'h5B, chal_q);
        chk("model", 8'h01, {7'h0, mut_q});
        chk("auth resp", 8'hA4, r[15:8]);
        chk("auth crc", crc8(32'hA4, 8), r[7:0]);
        chk("status", 8'h10, status_out);
    endtask
    initial begin
        logic [4:0] wa [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h11, 5'h15, 5'h16};
        logic [7:0] wd [7] = '{8'hA5, 8'h3C, 8'h96, 8'h0F, 8'h04, 8'h08, 8'h08};
        repeat (5) @(negedge ref_clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 7; i++) begin
            @(negedge ref_clk_in);
            nvm_we_in = 1'b1;
            nvm_waddr_in = wa[i];
            nvm_wdata_in = wd[i];
        end
        @(negedge ref_clk_in);
        nvm_we_in = 1'b0;
        repeat (12) @(negedge ref_clk_in);
        chk("reset status", 8'h00, status_out);
        // with the clock enable low the header pattern must hold still
        en = 1'b0;
        ok = damp_out;
        repeat (16) @(negedge ref_clk_in);
        chk("freeze", {7'h0, ok}, {7'h0, damp_out});
        en = 1'b1;
        bs.open_link(ok);
        @(negedge ref_clk_in);
        chk("link open", 8'h01, {7'h0, ok & link_open_out});
        t_uid();
        t_err();
        t_stat(8'h01, 1);
        t_auth();
        // second status read over quad pulses with a biphase answer
        dl = QUAD_PULSE_LENGTH_CODING;
        ul = UL_BIPHASE;
        t_stat(8'h10, 2);
        finish_test();
    end
endmodule
